// File: logic/rbc_pkg.sv
package rbc_pkg;
   localparam int unsigned CLK_HZ             = 50_000_000;
   // Internal clocks held after the reset cause goes away
   localparam int unsigned RELEASE_CYCLES     = 64;
   localparam int unsigned RELEASE_W          = 7;
   localparam int unsigned POR_CYCLES         = 16;
   localparam int unsigned POR_W              = 5;
   localparam int unsigned SYNC_STAGES        = 2;
   // Pull-up disable bit positions
   localparam int unsigned PUD_W              = 3;
   localparam int unsigned PUD_RESET_BIT      = 0;
   localparam int unsigned PUD_BOOT_BIT       = 1;
   localparam int unsigned PUD_MEMMODE_BIT    = 2;
   localparam logic [2:0]  PUD_RESET_VALUE    = 3'h0;
   localparam logic        OSC_AMP_RESET      = 1'b0;
   // Boot mode bits: {flash_unsecured, external_boot}
   localparam logic [1:0]  MODE_INTERNAL      = 2'h0;
   typedef enum logic [1:0] {
      RBC_POR,
      RBC_HELD,
      RBC_COUNT,
      RBC_RUN
   } rbc_state_t;
endpackage : rbc_pkg

// File: logic/rbc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_sync
   import rbc_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   // First stage feeds only the second
   logic [WIDTH-1:0] meta;
   always_ff @(posedge clk) begin
      meta     <= async_in;
      sync_out <= meta;
   end
endmodule // rbc_sync
`default_nettype wire

// File: logic/rbc_reset_boot.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_reset_boot
   import rbc_pkg::*;
#(
   parameter int unsigned RELEASE_COUNT = RELEASE_CYCLES
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             reset_pin_n,
   input  wire logic             external_boot_strap,
   input  wire logic             ext_memory_mode_strap,
   input  wire logic             flash_secured,
   input  wire logic             clock_input_mode,
   input  wire logic [PUD_W-1:0] pullup_disable_wr,
   input  wire logic             pullup_disable_we,
   input  wire logic             osc_amplitude_mode_wr,
   input  wire logic             osc_amplitude_mode_we,
   output logic                  reset_out_pin_n,
   output logic                  chip_reset,
   output logic [PUD_W-1:0]      pullup_disable_reg,
   output logic                  reset_pullup_en,
   output logic                  boot_strap_pullup_disable,
   output logic                  osc_amplitude_mode_bit,
   output logic                  clock_input_mode_out,
   output logic [1:0]            op_mode_bits,
   output logic                  ext_memory_mode
);
   logic                 pin_n_s;
   logic                 boot_s;
   logic                 mem_s;
   logic                 sec_s;
   logic                 clkm_s;
   logic [POR_W-1:0]     por_cnt;
   logic                 por_done;
   logic [RELEASE_W-1:0] rel_cnt;
   rbc_state_t           state;
   rbc_state_t           next_state;
   logic                 cause;
   logic                 count_done;
   logic                 boot_req;
   logic                 next_reset;

   // Pins cross into clk domain first
   rbc_sync #(.WIDTH(5)) u_sync (
      .clk      (clk),
      .async_in ({reset_pin_n, external_boot_strap, ext_memory_mode_strap,
                  flash_secured, clock_input_mode}),
      .sync_out ({pin_n_s, boot_s, mem_s, sec_s, clkm_s})
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         por_cnt  <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_cnt  <= por_cnt + POR_W'(1);
         por_done <= (por_cnt == POR_W'(POR_CYCLES - 1));
      end
   end

   assign cause = !pin_n_s || !por_done;
   assign count_done = (rel_cnt == RELEASE_W'(RELEASE_COUNT - 1));

   always_comb begin
      next_state = state;
      unique case (state)
         RBC_POR:   if (por_done) next_state = RBC_HELD;
         RBC_HELD:  if (!cause) next_state = RBC_COUNT;
         RBC_COUNT: if (cause) next_state = RBC_HELD;
                    else if (count_done) next_state = RBC_RUN;
         RBC_RUN:   if (cause) next_state = RBC_HELD;
      endcase
   end

   assign next_reset = (next_state != RBC_RUN);

   always_ff @(posedge clk) begin
      if (srst) begin
         state   <= RBC_POR;
         rel_cnt <= '0;
      end else begin
         state   <= next_state;
         rel_cnt <= (state == RBC_COUNT && !cause) ? rel_cnt + RELEASE_W'(1) : '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         chip_reset      <= 1'b1;
         reset_out_pin_n <= 1'b0;
      end else begin
         chip_reset      <= next_reset;
         reset_out_pin_n <= !next_reset;
      end
   end

   assign boot_req = boot_s && !sec_s;

   always_ff @(posedge clk) begin
      if (srst) begin
         op_mode_bits    <= MODE_INTERNAL;
         ext_memory_mode <= 1'b0;
      end else if (chip_reset) begin
         op_mode_bits    <= sec_s ? MODE_INTERNAL : {1'b1, boot_req};
         // memory strap only with external boot
         ext_memory_mode <= boot_req && mem_s;
      end
   end

   // pull-up disable bits; amplitude resets zero
   // amplitude bit only, no relaxation controls
   always_ff @(posedge clk) begin
      if (srst || chip_reset) begin
         pullup_disable_reg     <= PUD_RESET_VALUE;
         osc_amplitude_mode_bit <= OSC_AMP_RESET;
      end else begin
         if (pullup_disable_we) pullup_disable_reg <= pullup_disable_wr;
         if (osc_amplitude_mode_we) osc_amplitude_mode_bit <= osc_amplitude_mode_wr;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reset_pullup_en           <= 1'b1;
         boot_strap_pullup_disable <= 1'b0;
         clock_input_mode_out      <= 1'b0;
      end else begin
         reset_pullup_en           <= !pullup_disable_reg[PUD_RESET_BIT];
         boot_strap_pullup_disable <= pullup_disable_reg[PUD_BOOT_BIT];
         clock_input_mode_out      <= clkm_s;
      end
   end
endmodule // rbc_reset_boot
`default_nettype wire

// File: verification/rbc_reset_boot_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_reset_boot_checker
   import rbc_pkg::*;
#(parameter int unsigned RELEASE_COUNT = RELEASE_CYCLES) (
   input wire logic             clk,
   input wire logic             srst,
   input wire logic             reset_pin_n,
   input wire logic             flash_secured,
   input wire logic             osc_amplitude_mode_wr,
   input wire logic             osc_amplitude_mode_we,
   input wire logic             reset_out_pin_n,
   input wire logic             chip_reset,
   input wire logic [PUD_W-1:0] pullup_disable_reg,
   input wire logic             reset_pullup_en,
   input wire logic             osc_amplitude_mode_bit,
   input wire logic [1:0]       op_mode_bits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_out_follows_reset:
      assert property (reset_out_pin_n != chip_reset) else $error("reset out wrong");
   a_pin_forces_reset:
      assert property (!reset_pin_n |-> ##[1:4] chip_reset) else $error("pin reset late");
   a_release_after_count:
      assert property ($fell(chip_reset) |-> $past(reset_pin_n, RELEASE_COUNT) && reset_pin_n)
      else $error("early release");
   a_pullup_off_bit:
      assert property (!chip_reset && !$past(chip_reset, 2) |->
         reset_pullup_en == !$past(pullup_disable_reg[PUD_RESET_BIT])) else $error("pullup");
   a_amp_write_taken:
      assert property (osc_amplitude_mode_we && !chip_reset |=>
         chip_reset || osc_amplitude_mode_bit == $past(osc_amplitude_mode_wr)) else $error("amp");
   a_amp_zero_reset:
      assert property (chip_reset && $past(chip_reset) |-> !osc_amplitude_mode_bit)
      else $error("amp not cleared");
   a_secured_internal:
      assert property ($fell(chip_reset) && flash_secured && $past(flash_secured, 8) |->
         op_mode_bits == MODE_INTERNAL) else $error("secured mode");
   a_mode_held:
      assert property (!chip_reset && !$past(chip_reset) |-> $stable(op_mode_bits))
      else $error("mode moved");
endmodule // rbc_reset_boot_checker
`default_nettype wire

// File: verification/rbc_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_board_model (
   input  wire logic full_reset,
   input  wire logic debug_reset,
   output logic      reset_pin_n,
   output logic      test_reset_n
);
   assign reset_pin_n  = !(full_reset || debug_reset);
   assign test_reset_n = !full_reset;
endmodule // rbc_board_model
`default_nettype wire

// File: verification/rbc_reset_boot_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_reset_boot_tb;
   import rbc_pkg::*;
   logic       clk = 0, srst = 1, full = 0, dbg = 0, sec = 0, ext = 0, mem = 0, cim = 0;
   logic       pwe = 0, awr = 0, awe = 0, pin_n, rout_n, crst, rpe, bspd, amp, cimo, emm;
   logic       trst_n;
   logic [2:0] pwr = 0, pud;
   logic [1:0] opm;
   int         errors = 0, samples_checked = 0;
   always #10 clk = ~clk;
   rbc_board_model i_rbc_board_model (.full_reset(full), .debug_reset(dbg),
      .reset_pin_n(pin_n), .test_reset_n(trst_n));
   rbc_reset_boot #(.RELEASE_COUNT(4)) i_rbc_reset_boot (.clk(clk), .srst(srst),
      .reset_pin_n(pin_n), .external_boot_strap(ext), .ext_memory_mode_strap(mem),
      .flash_secured(sec), .clock_input_mode(cim), .pullup_disable_wr(pwr),
      .pullup_disable_we(pwe), .osc_amplitude_mode_wr(awr), .osc_amplitude_mode_we(awe),
      .reset_out_pin_n(rout_n), .chip_reset(crst), .pullup_disable_reg(pud),
      .reset_pullup_en(rpe), .boot_strap_pullup_disable(bspd), .osc_amplitude_mode_bit(amp),
      .clock_input_mode_out(cimo), .op_mode_bits(opm), .ext_memory_mode(emm));
   task automatic chk(input logic [2:0] s, input logic [2:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [2:0] p, input logic a);
      @(negedge clk);
      {pwr, awr, pwe, awe} = {p, a, 2'b11};
      @(negedge clk);
      {pwe, awe} = 2'b00;
      @(negedge clk);
   endtask
   task automatic boot(input logic f, input logic d, input logic [2:0] sxm);
      @(negedge clk);
      {full, dbg, sec, ext, mem} = {f, d, sxm};
      repeat (8) @(negedge clk);
      chk({crst, rout_n, pud[0]}, 3'b100);
      chk({2'b00, trst_n}, {2'b00, !f});
      {full, dbg} = 2'b00;
      for (int i = 0; i < 200 && crst !== 1'b0; i++) @(negedge clk);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      srst = 0;
      boot(0, 0, 3'b000);
      chk({rout_n, amp, 1'b0}, {1'b1, OSC_AMP_RESET, 1'b0});
      chk({rpe, opm}, {1'b1, 2'b10});
      wr(3'h7, 1);
      chk(pud, 3'h7);
      chk({rpe, bspd, amp}, 3'b011);
      wr(3'h0, 0);
      chk({rpe, bspd, amp}, 3'b100);
      wr(3'h1, 1);
      boot(0, 1, 3'b000);
      chk({rpe, amp, 1'b0}, 3'b100);
      for (int i = 0; i < 4; i++) begin
         boot(1, 0, {i[1:0], 1'b1});
         chk({emm, opm}, {i[0] & !i[1], i[1] ? MODE_INTERNAL : {1'b1, i[0]}});
         {sec, ext} = ~{sec, ext};
         cim = i[0];
         repeat (6) @(negedge clk);
         chk({cimo, opm}, {i[0], i[1] ? MODE_INTERNAL : {1'b1, i[0]}});
      end
      wr(3'h6, 1);
      chk({cimo, amp, bspd}, 3'b111);
      stop_test;
   end
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      stop_test;
   end
endmodule // rbc_reset_boot_tb
bind rbc_reset_boot rbc_reset_boot_checker #(.RELEASE_COUNT(RELEASE_COUNT)) i_chk (.clk, .srst,
   .reset_pin_n, .flash_secured, .osc_amplitude_mode_wr, .osc_amplitude_mode_we,
   .reset_out_pin_n, .chip_reset, .pullup_disable_reg, .reset_pullup_en,
   .osc_amplitude_mode_bit, .op_mode_bits);
`default_nettype wire
